// ---- core/trace_consts.svh ----
// Constants of the debug trace buffer unit: offsets, fields, encodings.
// Assumes inclusion by bare name; definitions only.
`ifndef TRACE_CONSTS_SVH
`define TRACE_CONSTS_SVH

// ==================================================================
// Register map (word aligned byte addresses)
`define OFS_CTRL 4'h0
`define OFS_BASE 4'h4
`define OFS_STAT 4'h8

// ==================================================================
// Control register fields
`define CTRL_EN_BIT 15
`define CTRL_FULL_BIT 14
`define CTRL_TMODE_HI 11
`define CTRL_TMODE_LO 10
`define CTRL_BMODE_HI 7
`define CTRL_BMODE_LO 6
`define CTRL_SIZE_HI 3
`define CTRL_SIZE_LO 0
`define CTRL_RESET 32'h0000_0000
`define BASE_RESET 32'h0000_0000

// ==================================================================
// Encodings
`define TMODE_CALL 2'h1
`define TMODE_BRANCH 2'h2
`define TMODE_DATA 2'h3
`define BMODE_SINGLE 2'h0
`define BMODE_CIRC 2'h1
`define BMODE_SIMPLE 2'h2
`define BW_MODE_TRACE 2'h1
`define MASTER_CTX 3'h0
`define SIZE_LOG_MIN 5'h05
`define REC_BYTES 32'h0000_0004
`define BREAKPOINT_EXCEPTION_VECTOR 8'h0C
`define TAG_ADDR 2'h1
`define TAG_CTX 2'h2
`define TAG_DATA 2'h3

`endif

// ---- core/trace_pkg.sv ----
// Types of the debug trace buffer unit.
// Assumes trace_consts.svh for the numeric values.
package trace_pkg;
   // Control transfer event classes from the execution unit
   typedef enum logic [3:0] {
      EV_NONE, EV_BRANCH_TO_SUBROUTINE, EV_JUMP_TO_SUBROUTINE,
      EV_RETURN_AND_DEALLOCATE, EV_RETURN_FROM_EXCEPTION,
      EV_RETURN_RESTORE_CODES, EV_RETURN_SUBROUTINE, EV_INTERRUPT,
      EV_EXCEPTION, EV_BRANCH_ALWAYS, EV_UNCONDITIONAL_JUMP,
      EV_COND_BRANCH, EV_DEC_BRANCH
   } event_type;
   // Tracer state
   typedef enum logic [1:0] {ST_IDLE, ST_TRACE, ST_WRITE} trc_state_type;
endpackage

// ---- core/trace_filter.sv ----
// Decides whether an execution event is recorded in the current mode.
// Assumes event class and taken flag from the execution unit.
`timescale 1ns/1ns
`include "trace_consts.svh"
module trace_filter
   import trace_pkg::*;
(
   input wire event_type ev,
   input wire logic taken,
   input wire logic [1:0] tmode,
   output logic record
);
   // ==================================================================
   // Classification
   // Call class: calls, returns, interrupts, exceptions
   function automatic logic is_call(input event_type e);
      is_call = (e inside {EV_BRANCH_TO_SUBROUTINE, EV_JUMP_TO_SUBROUTINE,
         EV_RETURN_AND_DEALLOCATE, EV_RETURN_FROM_EXCEPTION,
         EV_RETURN_RESTORE_CODES, EV_RETURN_SUBROUTINE, EV_INTERRUPT,
         EV_EXCEPTION});
   endfunction

   // Record decision per mode
   always_comb begin
      record = 1'b0;
      if (tmode == `TMODE_CALL) begin
         record = is_call(ev);
      end else if (tmode == `TMODE_BRANCH) begin
         record = is_call(ev) ||
            (ev inside {EV_BRANCH_ALWAYS, EV_UNCONDITIONAL_JUMP}) ||
            ((ev inside {EV_COND_BRANCH, EV_DEC_BRANCH}) && taken);
      end
   end
endmodule

// ---- core/trace_ptr.sv ----
// Write pointer generator for the three buffer disciplines.
// Assumes base aligned to the selected size by software.
`timescale 1ns/1ns
`include "trace_consts.svh"
module trace_ptr #(
   parameter int ADDR_W = 32
) (
   input wire logic [ADDR_W-1:0] base,
   input wire logic [3:0] size_code,
   input wire logic [1:0] bmode,
   input wire logic [ADDR_W-1:0] offset,
   output logic [ADDR_W-1:0] addr,
   output logic [ADDR_W-1:0] next_offset,
   output logic last
);
   // Capacity mask in bytes
   logic [ADDR_W-1:0] mask;
   logic [ADDR_W-1:0] bump;

   // Address and wrap computation
   always_comb begin
      mask = (ADDR_W'(1) << (`SIZE_LOG_MIN + 5'(size_code))) - ADDR_W'(1);
      bump = offset + ADDR_W'(`REC_BYTES);
      last = (bump & mask) == '0;
      addr = base;
      next_offset = '0;
      if (bmode != `BMODE_SINGLE) begin
         addr = base | (offset & mask);
         next_offset = bump & mask;
      end
   end
endmodule

// ---- core/trace_unit.sv ----
// Debug trace buffer unit: control registers, event capture, record writer.
// Assumes Avalon-MM register master, execution unit event strobes and a
// memory write port with ready; one clock, synchronous reset.
`timescale 1ns/1ns
`include "trace_consts.svh"
module trace_unit
   import trace_pkg::*;
#(
   parameter int ADDR_W = 32
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic [2:0] WRITER_CONTEXT,
   input wire logic BW_EVENT,
   input wire logic [1:0] BW_MODE,
   input wire event_type EXEC_EVENT,
   input wire logic EXEC_TAKEN,
   input wire logic [31:0] EXEC_ADDR,
   input wire logic CTX_SWITCH,
   input wire logic [2:0] CTX_NEW,
   input wire logic DACC_VALID,
   input wire logic DACC_IN_BLOCK,
   input wire logic DACC_DMA,
   input wire logic [31:0] DACC_DATA,
   output logic MEM_VALID,
   input wire logic MEM_READY,
   output logic [ADDR_W-1:0] MEM_ADDR,
   output logic [31:0] MEM_DATA,
   output logic [1:0] MEM_TAG,
   output logic BREAKPOINT_EXCEPTION_REQ,
   output logic [7:0] BREAKPOINT_EXCEPTION_VECTOR
);
   // ==================================================================
   // State
   typedef struct packed {
      logic en;                  // Trace enable
      logic full;                // Simple buffer full
      logic [1:0] tmode;         // Trace mode
      logic [1:0] bmode;         // Buffer mode
      logic [3:0] size;          // Buffer size code
      logic [31:0] base;         // Buffer base
      logic [ADDR_W-1:0] offset; // Write offset
      logic pend;                // Record waiting for memory
      logic [31:0] rdata;        // Pending payload
      logic [1:0] rtag;          // Pending tag
      logic [ADDR_W-1:0] raddr;  // Pending address
      logic rlast;               // Pending record fills buffer
      logic ack;                 // Bus answer phase
      logic [31:0] bus_rd;       // Bus read data
      logic breakpoint_exception;                // Exception pulse
      logic dropped;             // Record lost while busy
   } state_type;

   state_type s_q;
   state_type s_d;

   // Helper decode outputs
   logic rec_exec;
   logic [ADDR_W-1:0] wr_addr;
   logic [ADDR_W-1:0] nxt_off;
   logic wr_last;

   // ==================================================================
   // Submodules
   // Event filter per trace mode
   trace_filter u_filter (
      .ev(EXEC_EVENT),
      .taken(EXEC_TAKEN),
      .tmode(s_q.tmode),
      .record(rec_exec)
   );

   // Pointer generator
   trace_ptr #(.ADDR_W(ADDR_W)) u_ptr (
      .base(ADDR_W'(s_q.base)),
      .size_code(s_q.size),
      .bmode(s_q.bmode),
      .offset(s_q.offset),
      .addr(wr_addr),
      .next_offset(nxt_off),
      .last(wr_last)
   );

   // Legal mode check
   function automatic logic modes_ok(input logic [1:0] t, input logic [1:0] b);
      modes_ok = (t != 2'h0) && (b != 2'h3);
   endfunction

   // ==================================================================
   // Next state
   always_comb begin
      logic wr;
      logic rd;
      logic start;
      logic have;
      logic [31:0] pay;
      logic [1:0] tag;
      logic fill;
      logic lost;
      wr = 1'b0;
      rd = 1'b0;
      start = 1'b0;
      have = 1'b0;
      pay = '0;
      tag = '0;
      fill = 1'b0;
      lost = 1'b0;
      s_d = s_q;
      s_d.breakpoint_exception = 1'b0;
      s_d.ack = 1'b0;
      // One wait cycle; read data is latched in it so it stands after
      if ((AVS_READ || AVS_WRITE) && !s_q.ack) begin
         s_d.ack = 1'b1;
      end
      wr = AVS_WRITE && s_q.ack;
      rd = AVS_READ && !s_q.ack;

      // Memory handshake retires record
      if (s_q.pend && MEM_READY) begin
         s_d.pend = 1'b0;
         if (s_q.bmode != `BMODE_SINGLE) begin
            s_d.offset = nxt_off;
         end
         if (s_q.bmode == `BMODE_SIMPLE && s_q.rlast) begin
            fill = 1'b1;
            s_d.breakpoint_exception = 1'b1;
         end
      end

      // Record sources, context switch first
      if (s_q.en && modes_ok(s_q.tmode, s_q.bmode)) begin
         if (CTX_SWITCH) begin
            have = 1'b1;
            pay = 32'(CTX_NEW);
            tag = `TAG_CTX;
         end else if (s_q.tmode == `TMODE_DATA) begin
            have = DACC_VALID && DACC_IN_BLOCK && !DACC_DMA;
            pay = DACC_DATA;
            tag = `TAG_DATA;
         end else begin
            have = rec_exec;
            pay = EXEC_ADDR;
            tag = `TAG_ADDR;
         end
      end
      if (have && s_d.en) begin
         if (!s_q.pend) begin
            s_d.pend = 1'b1;
            s_d.rdata = pay;
            s_d.rtag = tag;
            s_d.raddr = wr_addr;
            s_d.rlast = wr_last;
         end else begin
            lost = 1'b1;
         end
      end

      // Register writes
      // Master context only
      if (wr && WRITER_CONTEXT == `MASTER_CTX) begin
         if (AVS_ADDRESS == `OFS_CTRL) begin
            if (AVS_BYTEENABLE[1]) begin
               s_d.en = AVS_WRITEDATA[`CTRL_EN_BIT];
               start = AVS_WRITEDATA[`CTRL_EN_BIT] && !s_q.en;
               if (AVS_WRITEDATA[`CTRL_FULL_BIT]) begin
                  s_d.full = 1'b0;
               end
               s_d.tmode = AVS_WRITEDATA[`CTRL_TMODE_HI:`CTRL_TMODE_LO];
            end
            if (AVS_BYTEENABLE[0]) begin
               s_d.bmode = AVS_WRITEDATA[`CTRL_BMODE_HI:`CTRL_BMODE_LO];
               s_d.size = AVS_WRITEDATA[`CTRL_SIZE_HI:`CTRL_SIZE_LO];
            end
         end else if (AVS_ADDRESS == `OFS_BASE) begin
            for (int i = 0; i < 4; i++) begin
               if (AVS_BYTEENABLE[i]) begin
                  s_d.base[8*i +: 8] = AVS_WRITEDATA[8*i +: 8];
               end
            end
         end else if (AVS_ADDRESS == `OFS_STAT && AVS_WRITEDATA[0]) begin
            s_d.dropped = 1'b0;
         end
      end

      // Hardware set wins over a same-cycle clear
      if (fill) begin
         s_d.full = 1'b1;
         s_d.en = 1'b0;
      end
      if (lost) begin
         s_d.dropped = 1'b1;
      end

      if (BW_EVENT && BW_MODE == `BW_MODE_TRACE && !s_q.full && !s_q.en &&
         !fill) begin
         s_d.en = 1'b1;
         start = 1'b1;
      end
      if (start) begin
         s_d.offset = '0;
      end

      // Read data, shown while waitrequest is low
      s_d.bus_rd = '0;
      if (rd) begin
         unique case (AVS_ADDRESS)
            `OFS_CTRL: s_d.bus_rd = {16'h0000, s_q.en, s_q.full, 2'h0,
               s_q.tmode, 2'h0, s_q.bmode, 2'h0, s_q.size};
            `OFS_BASE: s_d.bus_rd = s_q.base;
            `OFS_STAT: s_d.bus_rd = {30'h0000_0000, s_q.pend, s_q.dropped};
            default: s_d.bus_rd = '0;
         endcase
      end
   end

   // ==================================================================
   // Register stage
   always_ff @(posedge CLK) begin
      if (RST) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ==================================================================
   // Outputs
   assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !s_q.ack;
   assign AVS_READDATA = s_q.bus_rd;
   assign MEM_VALID = s_q.pend;
   assign MEM_ADDR = s_q.raddr;
   assign MEM_DATA = s_q.rdata;
   assign MEM_TAG = s_q.rtag;
   assign BREAKPOINT_EXCEPTION_REQ = s_q.breakpoint_exception;
   assign BREAKPOINT_EXCEPTION_VECTOR = `BREAKPOINT_EXCEPTION_VECTOR;

   // ==================================================================
   // Checks
   // Non-master write ignored
   AST_NONMASTER: assert property (@(posedge CLK) disable iff (RST)
      AVS_WRITE && !AVS_WAITREQUEST && WRITER_CONTEXT != `MASTER_CTX &&
      !BW_EVENT && AVS_ADDRESS == `OFS_BASE |=> $stable(s_q.base))
      else $error("base changed by non-master");
   AST_FULLBLOCK: assert property (@(posedge CLK) disable iff (RST)
      s_q.full && !s_q.en && !AVS_WRITE |=> !s_q.en)
      else $error("trace started while full");
   AST_START: assert property (@(posedge CLK) disable iff (RST)
      BW_EVENT && BW_MODE == `BW_MODE_TRACE && !s_q.full && !s_q.en &&
      !s_q.pend |=> s_q.en)
      else $error("event did not start trace");
   AST_BREAKPOINT_EXCEPTION: assert property (@(posedge CLK) disable iff (RST)
      BREAKPOINT_EXCEPTION_REQ |-> s_q.full && BREAKPOINT_EXCEPTION_VECTOR == `BREAKPOINT_EXCEPTION_VECTOR)
      else $error("exception without full");
   AST_CIRC: assert property (@(posedge CLK) disable iff (RST)
      s_q.bmode == `BMODE_CIRC && !s_q.full && !AVS_WRITE |=> !s_q.full)
      else $error("circular set full");
   AST_SINGLE: assert property (@(posedge CLK) disable iff (RST)
      !s_q.pend && s_d.pend && s_q.bmode == `BMODE_SINGLE
      |=> MEM_ADDR == $past(s_q.base))
      else $error("single mode moved address");
   AST_DMA: assert property (@(posedge CLK) disable iff (RST)
      !s_q.pend && DACC_DMA && !CTX_SWITCH && s_q.tmode == `TMODE_DATA
      |=> !s_q.pend)
      else $error("dma access recorded");
   AST_FULLSET: assert property (@(posedge CLK) disable iff (RST)
      s_q.pend && MEM_READY && s_q.rlast && s_q.bmode == `BMODE_SIMPLE
      |=> s_q.full && !s_q.en && BREAKPOINT_EXCEPTION_REQ)
      else $error("full not set at capacity");
   AST_RSVZERO: assert property (@(posedge CLK) disable iff (RST)
      AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == `OFS_CTRL |->
      AVS_READDATA == {16'h0000, AVS_READDATA[`CTRL_EN_BIT:`CTRL_FULL_BIT],
      2'h0, AVS_READDATA[`CTRL_TMODE_HI:`CTRL_TMODE_LO], 2'h0,
      AVS_READDATA[`CTRL_BMODE_HI:`CTRL_BMODE_LO], 2'h0,
      AVS_READDATA[`CTRL_SIZE_HI:`CTRL_SIZE_LO]})
      else $error("reserved control bits not zero");
   AST_NONMASTERCTL: assert property (@(posedge CLK) disable iff (RST)
      AVS_WRITE && !AVS_WAITREQUEST && WRITER_CONTEXT != `MASTER_CTX
      |=> $stable(s_q.tmode) && $stable(s_q.bmode) && $stable(s_q.size))
      else $error("control changed by non-master");
   // Full holds without write of one
   AST_FULLHOLD: assert property (@(posedge CLK) disable iff (RST)
      s_q.full && !(AVS_WRITE && !AVS_WAITREQUEST &&
      WRITER_CONTEXT == `MASTER_CTX && AVS_ADDRESS == `OFS_CTRL &&
      AVS_BYTEENABLE[1] && AVS_WRITEDATA[`CTRL_FULL_BIT]) |=> s_q.full)
      else $error("full flag cleared without write of one");
   AST_CIRCEN: assert property (@(posedge CLK) disable iff (RST)
      s_q.bmode == `BMODE_CIRC && s_q.en && !AVS_WRITE |=> s_q.en)
      else $error("circular cleared enable");
   AST_STOP: assert property (@(posedge CLK) disable iff (RST)
      s_q.full && !s_q.en && !s_q.pend |=> !s_q.pend)
      else $error("record after buffer full");
   AST_RSVMODE: assert property (@(posedge CLK) disable iff (RST)
      !modes_ok(s_q.tmode, s_q.bmode) && !s_q.pend |=> !s_q.pend)
      else $error("record in reserved mode");
   AST_PTRSTART: assert property (@(posedge CLK) disable iff (RST)
      $rose(s_q.en) |-> s_q.offset == '0)
      else $error("pointer not restarted");
   AST_DATAVAL: assert property (@(posedge CLK) disable iff (RST)
      s_q.en && s_q.tmode == `TMODE_DATA && modes_ok(s_q.tmode, s_q.bmode)
      && !s_q.pend && !CTX_SWITCH && DACC_VALID && DACC_IN_BLOCK &&
      !DACC_DMA |=> MEM_DATA == $past(DACC_DATA) && MEM_TAG == `TAG_DATA)
      else $error("data record wrong");
endmodule

// ---- verif/mem_sink.sv ----
// Memory write path model: takes trace records with random stalls.
// Assumes the clock and reset of the trace unit.
`timescale 1ns/1ns
module mem_sink (
   input wire logic clk,
   input wire logic rst,
   input wire logic valid,
   input wire logic [31:0] addr,
   input wire logic [31:0] data,
   input wire logic [1:0] tag,
   output logic ready,
   output int count,
   output logic [31:0] got_addr,
   output logic [31:0] got_data,
   output logic [1:0] got_tag
);
   // ===========================================================
   // Record capture
   // Ready drawn at random, so the writer sees prompt and slow answers
   always @(posedge clk) begin
      if (rst) begin
         ready <= 1'b0;
         count <= 0;
      end else begin
         ready <= ($urandom % 3) != 0;
         // Handshake retires one record
         if (valid && ready) begin
            count <= count + 1;
            got_addr <= addr;
            got_data <= data;
            got_tag <= tag;
         end
      end
   end
endmodule

// ---- verif/trace_unit_tb.sv ----
// Testbench of the trace unit: registers, event capture, buffer modes.
// Assumes the design files and mem_sink are compiled before it.
`timescale 1ns/1ns
`include "trace_consts.svh"
module trace_unit_tb import trace_pkg::*; ;
   // ===========================================================
   // Signals
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic [3:0] a_adr = 4'h0;
   logic a_rd = 1'b0, a_wr = 1'b0, wreq, mval, mrdy, bkq;
   logic [31:0] a_wd = 32'h0, a_rdata, eadr = 32'h0, dd = 32'h0;
   logic [2:0] wctx = 3'h0, cnew = 3'h0;
   logic bw = 1'b0, cs = 1'b0, tk = 1'b0, dv = 1'b0, dib = 1'b0;
   logic dma = 1'b0;
   logic [1:0] bwm = 2'h0, mtag, gtag;
   logic [7:0] bkv;
   logic [31:0] maddr, mdata, gadr, gdat, base, r, x;
   event_type ev = EV_NONE;
   int cnt, bad_count = 0, comparisons = 0, cyc = 0, bk_n = 0, c;
   // Clock of 4 ns
   always #2 CLK = ~CLK;
   trace_unit dut_u (.CLK(CLK), .RST(RST), .AVS_ADDRESS(a_adr),
      .AVS_READ(a_rd), .AVS_WRITE(a_wr), .AVS_WRITEDATA(a_wd),
      .AVS_BYTEENABLE(4'hF), .AVS_READDATA(a_rdata),
      .AVS_WAITREQUEST(wreq), .WRITER_CONTEXT(wctx), .BW_EVENT(bw),
      .BW_MODE(bwm), .EXEC_EVENT(ev), .EXEC_TAKEN(tk), .EXEC_ADDR(eadr),
      .CTX_SWITCH(cs), .CTX_NEW(cnew), .DACC_VALID(dv),
      .DACC_IN_BLOCK(dib), .DACC_DMA(dma), .DACC_DATA(dd),
      .MEM_VALID(mval), .MEM_READY(mrdy), .MEM_ADDR(maddr),
      .MEM_DATA(mdata), .MEM_TAG(mtag), .BREAKPOINT_EXCEPTION_REQ(bkq),
      .BREAKPOINT_EXCEPTION_VECTOR(bkv));
   mem_sink snk_u (.clk(CLK), .rst(RST), .valid(mval), .addr(maddr),
      .data(mdata), .tag(mtag), .ready(mrdy), .count(cnt),
      .got_addr(gadr), .got_data(gdat), .got_tag(gtag));
   // ===========================================================
   // Checking and closing
   task automatic chk(input string n, input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Cycle ceiling and exception pulse count
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (bkq === 1'b1) bk_n <= bk_n + 1;
      if (cyc == 30000) begin
         bad_count++;
         finish_test();
      end
   end
   // ===========================================================
   // Avalon master: hold request until waitrequest seen low
   task automatic bus(input logic w, input logic [2:0] cx,
      input logic [3:0] a, input logic [31:0] d);
      @(posedge CLK);
      a_wr <= w;
      a_rd <= !w;
      a_adr <= a;
      a_wd <= d;
      wctx <= cx;
      do begin
         @(posedge CLK);
      end while (wreq !== 1'b0);
      r = a_rdata;
      a_wr <= 1'b0;
      a_rd <= 1'b0;
   endtask
   // Read and compare
   task automatic rdc(input string n, input logic [3:0] a,
      input logic [31:0] e);
      bus(1'b0, 3'h0, a, 32'h0);
      chk(n, r, e);
   endtask
   // One-cycle source pulse
   task automatic fire(input logic s, input event_type e, input logic t,
      input logic v, input logic b, input logic [31:0] d);
      @(posedge CLK);
      cs <= s;
      ev <= e;
      tk <= t;
      dv <= v;
      bw <= b;
      eadr <= d;
      dd <= ~d;
      cnew <= d[2:0];
      @(posedge CLK);
      cs <= 1'b0;
      ev <= EV_NONE;
      dv <= 1'b0;
      bw <= 1'b0;
   endtask
   // Expect a record, or its absence, at the memory port
   task automatic rec(input logic y, input logic [31:0] a, d,
      input logic [1:0] t);
      int c0;
      int n;
      c0 = cnt;
      n = 0;
      while (cnt == c0 && n < 40) begin
         @(posedge CLK);
         n++;
      end
      chk("record", {31'h0, cnt != c0}, {31'h0, y});
      if (y && cnt != c0) begin
         chk("addr", gadr, a);
         chk("data", gdat, d);
         chk("tag", {30'h0, gtag}, {30'h0, t});
      end
   endtask
   function automatic logic [31:0] ctl(input logic e, f,
      input logic [1:0] tm, bm, input logic [3:0] sz);
      return {16'h0, e, f, 2'h0, tm, 2'h0, bm, 2'h0, sz};
   endfunction
   // Event classes recorded per trace mode
   function automatic logic want(input int tm, k, input logic t);
      if (tm == 1) return k >= 1 && k <= 8;
      if (tm == 2) return (k >= 1 && k <= 10) || (k >= 11 && t);
      return 1'b0;
   endfunction
   // ===========================================================
   // Main sequence
   initial begin
      void'($urandom(32'h0766F02D));
      repeat (20) @(posedge CLK);
      RST <= 1'b0;
      rdc("ctrl", `OFS_CTRL, `CTRL_RESET);
      rdc("base", `OFS_BASE, `BASE_RESET);
      rdc("unmapped", 4'hC, 32'h0);
      bus(1'b1, 3'h0, `OFS_CTRL, ctl(0, 0, 1, 2, 5) | 32'hFFFF_3330);
      rdc("ctrl", `OFS_CTRL, ctl(0, 0, 1, 2, 5));
      base = $urandom & 32'hFFFF_F000;
      bus(1'b1, 3'h0, `OFS_BASE, base);
      bus(1'b1, 3'h2, `OFS_BASE, ~base);
      bus(1'b1, 3'h3, `OFS_CTRL, ctl(1, 0, 3, 1, 9));
      rdc("base", `OFS_BASE, base);
      rdc("ctrl", `OFS_CTRL, ctl(0, 0, 1, 2, 5));
      for (int tm = 0; tm <= 2; tm++) begin
         bus(1'b1, 3'h0, `OFS_CTRL, ctl(1, 0, tm, `BMODE_SINGLE, 0));
         for (int k = 1; k <= 12; k++) begin
            for (int t = 0; t <= 1; t++) begin
               x = $urandom;
               fire(0, event_type'(k), t, 0, 0, x);
               rec(want(tm, k, t), base, x, `TAG_ADDR);
            end
         end
         c = $urandom % 5;
         fire(1, EV_NONE, 0, 0, 0, c);
         rec(tm != 0, base, c, `TAG_CTX);
      end
      // data values and context switches only, processor accesses in the block only
      bus(1'b1, 3'h0, `OFS_CTRL, ctl(1, 0, 3, `BMODE_SINGLE, 0));
      dib <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         x = $urandom;
         dma <= i[0];
         dib <= !i[1];
         fire(0, EV_NONE, 0, 1, 0, x);
         rec(i == 0, base, ~x, `TAG_DATA);
      end
      dma <= 1'b0;
      fire(0, EV_BRANCH_TO_SUBROUTINE, 1, 0, 0, x);
      rec(0, base, x, `TAG_ADDR);
      fire(1, EV_NONE, 0, 0, 0, 32'h4);
      rec(1, base, 32'h4, `TAG_CTX);
      bus(1'b1, 3'h0, `OFS_CTRL, ctl(1, 0, 2, `BMODE_CIRC, 0));
      for (int i = 0; i < 10; i++) begin
         x = $urandom;
         fire(0, EV_BRANCH_ALWAYS, 0, 0, 0, x);
         rec(1, base + 4 * (i % 8), x, `TAG_ADDR);
      end
      rdc("ctrl", `OFS_CTRL, ctl(1, 0, 2, 1, 0));
      // simple buffer of 64 bytes, a fresh trace
      bus(1'b1, 3'h0, `OFS_CTRL, ctl(0, 0, 1, `BMODE_SIMPLE, 1));
      bus(1'b1, 3'h0, `OFS_CTRL, ctl(1, 0, 1, `BMODE_SIMPLE, 1));
      for (int i = 0; i < 17; i++) begin
         c = $urandom % 5;
         fire(1, EV_NONE, 0, 0, 0, c);
         rec(i < 16, base + 4 * i, c, `TAG_CTX);
      end
      rdc("ctrl", `OFS_CTRL, ctl(0, 1, 1, 2, 1));
      chk("breakpoint_exception", bk_n, 1);
      chk("vector", {24'h0, bkv}, 32'h0C);
      bwm <= `BW_MODE_TRACE;
      fire(0, EV_NONE, 0, 0, 1, 0);
      rdc("ctrl", `OFS_CTRL, ctl(0, 1, 1, 2, 1));
      bus(1'b1, 3'h0, `OFS_CTRL, ctl(0, 0, 1, 2, 1));
      rdc("ctrl", `OFS_CTRL, ctl(0, 1, 1, 2, 1));
      bus(1'b1, 3'h0, `OFS_CTRL, ctl(0, 1, 1, 2, 1));
      rdc("ctrl", `OFS_CTRL, ctl(0, 0, 1, 2, 1));
      bwm <= 2'h2;
      fire(0, EV_NONE, 0, 0, 1, 0);
      rdc("ctrl", `OFS_CTRL, ctl(0, 0, 1, 2, 1));
      bwm <= `BW_MODE_TRACE;
      fire(0, EV_NONE, 0, 0, 1, 0);
      rdc("ctrl", `OFS_CTRL, ctl(1, 0, 1, 2, 1));
      fire(1, EV_NONE, 0, 0, 0, 32'h3);
      rec(1, base, 32'h3, `TAG_CTX);
      bus(1'b1, 3'h0, `OFS_CTRL, ctl(0, 0, 1, 2, 1));
      fire(1, EV_NONE, 0, 0, 0, 32'h2);
      rec(0, base, 32'h2, `TAG_CTX);
      finish_test();
   end
endmodule
